// ---- rtl/spc_ctrl.sv ----
// Power mode sequencer, clock gating, oscillator select and reset control
`timescale 1ns/1ps
module spc_ctrl
  import spc_pkg::*;
(
  input  wire logic                           clk,
  input  wire logic                           rst_n,
  input  wire logic                           supply_good,
  input  wire logic                           brownout,
  input  wire logic                           external_reset_pin_n,
  input  wire logic                           soft_rst_req,
  input  wire logic                           sleep_req,
  input  wire logic                           deep_req,
  input  wire logic                           wake_event,
  input  wire logic                           freq_sel,
  input  wire logic [NUM_DIV-1:0][DIV_W-1:0]  div_val,
  input  wire logic                           lfo_tick,
  input  wire logic                           wdt_enable,
  input  wire logic                           wdt_kick,
  input  wire logic [WDT_W-1:0]               wdt_timeout,
  input  wire logic                           cause_clr,
  output spc_mode_t                           mode_o,
  output spc_gate_t                           gate_o,
  output logic                                hf_osc_en_o,
  output logic                                osc_sel_o,
  output logic [NUM_DIV-1:0]                  periph_tick_o,
  output logic                                sys_rst_n_o,
  output spc_cause_t                          cause_o,
  output logic [WDT_W-1:0]                    wdt_count_o
);

  // ***********************************************
  // Declarations
  // ***********************************************
  spc_state_t       state_reg;
  spc_state_t       state_next;
  logic [11:0]      settle_reg;
  logic [11:0]      settle_next;
  logic [1:0]       gap_reg;
  logic [1:0]       gap_next;
  logic             osc_sel_next;
  spc_mode_t        mode_next;
  spc_gate_t        gate_next;
  logic             hf_next;
  logic             wake_meta_reg;
  logic             wake_sync_reg;
  logic [2:0]       hold_reg;
  logic [2:0]       hold_next;
  spc_cause_t       cause_next;
  spc_cause_t       src;
  logic             rst_src;
  logic             sys_active;
  logic             wdt_expire;

  // ***********************************************
  // Wake synchroniser
  // ***********************************************
  // Wake may arrive while the fast clock is restarting; two flops keep
  // metastability out, and these flops are never gated
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_meta_reg <= 1'b0;
      wake_sync_reg <= 1'b0;
    end else begin
      wake_meta_reg <= wake_event;
      wake_sync_reg <= wake_meta_reg;
    end
  end

  // ***********************************************
  // Reset sources and hold
  // ***********************************************
  // Pin and brown-out act on the reset output with no clock at all;
  // software and watchdog requests are stretched by the hold counter
  always_comb begin
    src.watchdog = wdt_expire;
    src.software = soft_rst_req;
    src.pin      = !external_reset_pin_n;
    src.brownout = brownout;
    src.power_on = 1'b0;
    rst_src      = |src;
    hold_next    = hold_reg;
    if (rst_src) begin
      hold_next = RST_HOLD;
    end else if (hold_reg != 3'h0) begin
      hold_next = hold_reg - 3'h1;
    end
  end

  assign sys_active  = (hold_reg != 3'h0) || src.pin || src.brownout;
  assign sys_rst_n_o = rst_n && !sys_active;

  // Cause record is reset only by power-on, so it survives the resets
  // it describes; a new reset replaces it, a running one adds bits
  always_comb begin
    cause_next = cause_o;
    if (cause_clr) begin
      cause_next = '0;
    end
    if (rst_src && hold_reg == 3'h0) begin
      cause_next = src;
    end else if (rst_src) begin
      cause_next = cause_next | src;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_reg <= 3'h0;
      cause_o  <= CAUSE_RST;
    end else begin
      hold_reg <= hold_next;
      cause_o  <= cause_next;
    end
  end

  // ***********************************************
  // Mode sequencer
  // ***********************************************
  // Frequency change goes first, then deep sleep, then sleep
  always_comb begin
    state_next   = state_reg;
    settle_next  = settle_reg;
    gap_next     = gap_reg;
    osc_sel_next = osc_sel_o;
    if (sys_active) begin
      state_next   = ST_SUPPLY_WAIT;
      osc_sel_next = OSC_SEL_RST;
      settle_next  = 12'h0;
      gap_next     = 2'h0;
    end else begin
      case (state_reg)
        ST_SUPPLY_WAIT: begin
          if (supply_good) begin
            state_next = ST_ACTIVE;
          end
        end
        ST_ACTIVE: begin
          if (freq_sel != osc_sel_o) begin
            state_next = ST_SWITCH;
            gap_next   = 2'h0;
          end else if (deep_req) begin
            state_next = ST_DEEP;
          end else if (sleep_req) begin
            state_next = ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (wake_sync_reg) begin
            state_next = ST_ACTIVE;
          end
        end
        ST_DEEP: begin
          if (wake_sync_reg) begin
            state_next  = ST_HF_START;
            settle_next = 12'h0;
          end
        end
        ST_HF_START: begin
          if (settle_reg >= SETTLE_LAST) begin
            state_next = ST_ACTIVE;
          end else begin
            settle_next = settle_reg + 12'h1;
          end
        end
        ST_SWITCH: begin
          // Clocks stay stopped around the source change
          if (gap_reg == 2'h1) begin
            osc_sel_next = freq_sel;
          end
          if (gap_reg == SWITCH_GAP) begin
            state_next = ST_ACTIVE;
          end else begin
            gap_next = gap_reg + 2'h1;
          end
        end
        default: begin
          state_next = ST_SUPPLY_WAIT;
        end
      endcase
    end
  end

  // Gating follows the next state so outputs are registered
  always_comb begin
    case (state_next)
      ST_ACTIVE: begin
        gate_next = GATE_ALL;
        hf_next   = 1'b1;
        mode_next = MODE_ACTIVE;
      end
      ST_SLEEP: begin
        gate_next = GATE_SLEEP;
        hf_next   = 1'b1;
        mode_next = MODE_SLEEP;
      end
      ST_DEEP: begin
        gate_next = GATE_NONE;
        hf_next   = 1'b0;
        mode_next = MODE_DEEP;
      end
      ST_HF_START: begin
        gate_next = GATE_NONE;
        hf_next   = 1'b1;
        mode_next = MODE_DEEP;
      end
      ST_SWITCH: begin
        gate_next = GATE_NONE;
        hf_next   = 1'b1;
        mode_next = MODE_ACTIVE;
      end
      default: begin
        gate_next = GATE_NONE;
        hf_next   = 1'b1;
        mode_next = MODE_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg   <= ST_SUPPLY_WAIT;
      settle_reg  <= 12'h0;
      gap_reg     <= 2'h0;
      osc_sel_o   <= OSC_SEL_RST;
      gate_o      <= GATE_NONE;
      hf_osc_en_o <= 1'b1;
      mode_o      <= MODE_ACTIVE;
    end else begin
      state_reg   <= state_next;
      settle_reg  <= settle_next;
      gap_reg     <= gap_next;
      osc_sel_o   <= osc_sel_next;
      gate_o      <= gate_next;
      hf_osc_en_o <= hf_next;
      mode_o      <= mode_next;
    end
  end

  // ***********************************************
  // Dividers and watchdog
  // ***********************************************
  // Dividers stop with the peripheral gate so no partial tick escapes
  for (genvar i = 0; i < NUM_DIV; i++) begin : g_div
    spc_clk_div u_div (
      .clk     (clk),
      .rst_n   (rst_n),
      .clear   (sys_active),
      .run     (gate_o.periph),
      .div_val (div_val[i]),
      .tick_o  (periph_tick_o[i])
    );
  end

  spc_watchdog u_wdt (
    .clk      (clk),
    .rst_n    (rst_n),
    .clear    (sys_active),
    .enable   (wdt_enable),
    .kick     (wdt_kick),
    .lfo_tick (lfo_tick),
    .timeout  (wdt_timeout),
    .count_o  (wdt_count_o),
    .expire_o (wdt_expire)
  );

  // ***********************************************
  // Checks
  // ***********************************************
  logic [12:0] wake_cnt_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_cnt_reg <= 13'h0;
    end else if (state_reg == ST_HF_START || (state_reg == ST_DEEP && wake_sync_reg)) begin
      wake_cnt_reg <= wake_cnt_reg + 13'h1;
    end else begin
      wake_cnt_reg <= 13'h0;
    end
  end

  AST_ACTIVE_CLK: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == ST_ACTIVE |-> gate_o == GATE_ALL && hf_osc_en_o)
    else $error("active mode without all clocks");
  AST_SLEEP_GATE: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == ST_SLEEP |-> !gate_o.cpu && !gate_o.flash && !gate_o.sram && gate_o.periph)
    else $error("sleep gating wrong");
  AST_SLEEP_WAKE: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == ST_SLEEP && wake_sync_reg && !sys_active |=> gate_o.cpu)
    else $error("sleep wake not immediate");
  AST_DEEP_HF: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == ST_DEEP |-> !hf_osc_en_o && gate_o == GATE_NONE)
    else $error("fast clock on in deep sleep");
  AST_DEEP_WAKE: assert property (@(posedge clk) disable iff (!rst_n)
    wake_cnt_reg <= 13'(WAKE_CYC))
    else $error("deep sleep wake over budget");
  AST_SUPPLY_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == ST_SUPPLY_WAIT && !supply_good |=> state_reg == ST_SUPPLY_WAIT)
    else $error("mode entered without supply good");
  AST_BROWNOUT: assert property (@(posedge clk) disable iff (!rst_n)
    brownout |-> !sys_rst_n_o ##1 state_reg == ST_SUPPLY_WAIT)
    else $error("brown-out did not reset");
  AST_GLITCH: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(osc_sel_o) && !$past(sys_active) |-> gate_o == GATE_NONE
      && $past(gate_o) == GATE_NONE)
    else $error("clock source changed while clocks ran");
  AST_WDT_CAUSE: assert property (@(posedge clk) disable iff (!rst_n)
    wdt_expire |=> cause_o.watchdog && !sys_rst_n_o)
    else $error("watchdog reset not logged");
  AST_PIN_RST: assert property (@(posedge clk) disable iff (!rst_n)
    !external_reset_pin_n |-> !sys_rst_n_o)
    else $error("reset pin ignored");
  AST_RST_INIT: assert property (@(posedge clk) disable iff (!rst_n)
    sys_active |=> osc_sel_o == OSC_SEL_24 && wdt_count_o == '0)
    else $error("reset did not restore defaults");

  COV_SLEEP: cover property (@(posedge clk) disable iff (!rst_n)
    state_reg == ST_SLEEP ##[1:20] state_reg == ST_ACTIVE);
  COV_DEEP: cover property (@(posedge clk) disable iff (!rst_n)
    state_reg == ST_HF_START ##1 state_reg == ST_ACTIVE);
  COV_SWITCH: cover property (@(posedge clk) disable iff (!rst_n)
    $rose(osc_sel_o));
  COV_WDT: cover property (@(posedge clk) disable iff (!rst_n) wdt_expire);

endmodule

// ---- rtl/spc_pkg.sv ----
// Constants and types shared by the power, clock and reset controller
package spc_pkg;

  // ***********************************************
  // Timing
  // ***********************************************
  localparam int unsigned CLK_HZ     = 100_000_000;
  localparam int unsigned WAKE_US    = 35;
  // Longest time, so the division rounds down
  localparam int unsigned WAKE_CYC   = WAKE_US * (CLK_HZ / 1_000_000);
  // Sync stages and state steps eat four cycles of the budget
  localparam int unsigned SETTLE_CYC = WAKE_CYC - 4;
  localparam logic [11:0] SETTLE_LAST = 12'(SETTLE_CYC - 1);
  localparam int unsigned LFO_HZ     = 40_000;
  localparam logic [1:0]  SWITCH_GAP = 2'h3;
  localparam logic [2:0]  RST_HOLD   = 3'h4;

  // ***********************************************
  // Oscillator, dividers, watchdog
  // ***********************************************
  localparam int unsigned MAIN_LO_MHZ = 24;
  localparam int unsigned MAIN_HI_MHZ = 32;
  localparam logic        OSC_SEL_24  = 1'b0;
  localparam logic        OSC_SEL_32  = 1'b1;
  localparam logic        OSC_SEL_RST = OSC_SEL_24;
  localparam int unsigned NUM_DIV     = 4;
  localparam int unsigned DIV_W       = 16;
  localparam int unsigned WDT_W       = 16;

  // ***********************************************
  // Types
  // ***********************************************
  typedef enum logic [2:0] {
    ST_SUPPLY_WAIT, ST_ACTIVE, ST_SLEEP, ST_DEEP, ST_HF_START, ST_SWITCH
  } spc_state_t;

  typedef enum logic [1:0] {MODE_ACTIVE, MODE_SLEEP, MODE_DEEP} spc_mode_t;

  typedef struct packed {
    logic cpu;
    logic flash;
    logic sram;
    logic periph;
  } spc_gate_t;

  typedef struct packed {
    logic watchdog;
    logic software;
    logic pin;
    logic brownout;
    logic power_on;
  } spc_cause_t;

  localparam spc_cause_t CAUSE_RST  = 5'h01;
  localparam spc_gate_t  GATE_ALL   = 4'hf;
  localparam spc_gate_t  GATE_NONE  = 4'h0;
  localparam spc_gate_t  GATE_SLEEP = 4'h1;

endpackage

// ---- rtl/spc_clk_div.sv ----
// One peripheral clock divider producing a synchronous enable tick
`timescale 1ns/1ps
module spc_clk_div
  import spc_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             clear,
  input  wire logic             run,
  input  wire logic [DIV_W-1:0] div_val,
  output logic                  tick_o
);

  logic [DIV_W-1:0] cnt_reg;
  logic [DIV_W-1:0] cnt_next;
  logic             tick_next;

  // Tick once every div_val+1 processor clocks, stopped while gated
  always_comb begin
    cnt_next  = cnt_reg;
    tick_next = 1'b0;
    if (clear || !run) begin
      cnt_next = '0;
    end else if (cnt_reg >= div_val) begin
      cnt_next  = '0;
      tick_next = 1'b1;
    end else begin
      cnt_next = cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
      tick_o  <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick_o  <= tick_next;
    end
  end

  AST_DIV_PERIOD: assert property (@(posedge clk) disable iff (!rst_n)
    tick_o |-> cnt_reg == '0 && $past(cnt_reg) >= $past(div_val))
    else $error("divider tick without reaching divide value");

endmodule

// ---- rtl/spc_watchdog.sv ----
// Watchdog counter stepped by the low-frequency oscillator tick
`timescale 1ns/1ps
module spc_watchdog
  import spc_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             clear,
  input  wire logic             enable,
  input  wire logic             kick,
  input  wire logic             lfo_tick,
  input  wire logic [WDT_W-1:0] timeout,
  output logic      [WDT_W-1:0] count_o,
  output logic                  expire_o
);

  logic [WDT_W-1:0] count_next;
  logic             expire_next;

  // Not gated by any power mode, so it keeps counting in deep sleep
  always_comb begin
    count_next  = count_o;
    expire_next = 1'b0;
    if (clear || kick) begin
      count_next = '0;
    end else if (enable && lfo_tick) begin
      if (count_o >= timeout) begin
        count_next  = '0;
        expire_next = 1'b1;
      end else begin
        count_next = count_o + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_o  <= '0;
      expire_o <= 1'b0;
    end else begin
      count_o  <= count_next;
      expire_o <= expire_next;
    end
  end

  AST_WDT_KICK: assert property (@(posedge clk) disable iff (!rst_n)
    kick |=> count_o == '0 && !expire_o)
    else $error("watchdog not cleared by service write");

endmodule

// ---- dv/test_system_power_clock_reset_ctrl.sv ----
// Self-checking testbench for the power, clock and reset controller
`timescale 1ns/1ps
module test_system_power_clock_reset_ctrl;
  import spc_pkg::*;

  // ***********************************************
  // Signals and design
  // ***********************************************
  logic                          clk;
  logic                          rst_n;
  logic                          supply_good;
  logic                          brownout;
  logic                          external_reset_pin_n;
  logic                          soft_rst_req;
  logic                          sleep_req;
  logic                          deep_req;
  logic                          wake_event;
  logic                          freq_sel;
  logic [NUM_DIV-1:0][DIV_W-1:0] div_val;
  logic                          lfo_tick;
  logic                          wdt_enable;
  logic                          wdt_kick;
  logic [WDT_W-1:0]              wdt_timeout;
  logic                          cause_clr;
  spc_mode_t                     mode_o;
  spc_gate_t                     gate_o;
  logic                          hf_osc_en_o;
  logic                          osc_sel_o;
  logic [NUM_DIV-1:0]            periph_tick_o;
  logic                          sys_rst_n_o;
  spc_cause_t                    cause_o;
  logic [WDT_W-1:0]              wdt_count_o;
  int                            fail_count = 0;
  int                            n_checks = 0;

  spc_ctrl dut (.clk(clk), .rst_n(rst_n), .supply_good(supply_good), .brownout(brownout),
    .external_reset_pin_n(external_reset_pin_n), .soft_rst_req(soft_rst_req),
    .sleep_req(sleep_req), .deep_req(deep_req), .wake_event(wake_event),
    .freq_sel(freq_sel), .div_val(div_val), .lfo_tick(lfo_tick), .wdt_enable(wdt_enable),
    .wdt_kick(wdt_kick), .wdt_timeout(wdt_timeout), .cause_clr(cause_clr),
    .mode_o(mode_o), .gate_o(gate_o), .hf_osc_en_o(hf_osc_en_o), .osc_sel_o(osc_sel_o),
    .periph_tick_o(periph_tick_o), .sys_rst_n_o(sys_rst_n_o), .cause_o(cause_o),
    .wdt_count_o(wdt_count_o));

  // 100 MHz clock
  always #5 clk = ~clk;

  // ***********************************************
  // Shared tasks
  // ***********************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Inputs move and outputs are read 1 ns after the edge, once updates have landed
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Bounded wait for the system to run again with every clock enabled
  task automatic wait_active(input int max);
    int i;
    i = 0;
    while (!(sys_rst_n_o === 1'b1 && gate_o === GATE_ALL) && i < max) begin
      step(1);
      i++;
    end
    check(32'(i < max), 32'h1);
  endtask

  task automatic wait_mode(input spc_mode_t m, input int max);
    int i;
    i = 0;
    while (mode_o !== m && i < max) begin
      step(1);
      i++;
    end
    check(32'(mode_o), 32'(m));
  endtask

  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Hang guard: the sequence needs well under 10k cycles
  initial begin
    #300_000;
    fail_count++;
    $display("Timeout reached");
    wrap_up();
  end

  // ***********************************************
  // Main sequence
  // ***********************************************
  initial begin
    int n;
    clk = 1'b0; rst_n = 1'b0; supply_good = 1'b0; brownout = 1'b0;
    external_reset_pin_n = 1'b1; soft_rst_req = 1'b0; sleep_req = 1'b0;
    deep_req = 1'b0; wake_event = 1'b0; freq_sel = 1'b0; div_val = '0;
    lfo_tick = 1'b0; wdt_enable = 1'b0; wdt_kick = 1'b0; wdt_timeout = 16'h0003;
    cause_clr = 1'b0;
    void'($urandom(32'h8c7c));
    step(4);
    check(32'(mode_o), 32'(MODE_ACTIVE));
    check(32'(gate_o), 32'(GATE_NONE));
    check(32'(hf_osc_en_o), 32'h1);
    check(32'(osc_sel_o), 32'(OSC_SEL_RST));
    check(32'(cause_o), 32'(CAUSE_RST));
    check(32'(wdt_count_o), 32'h0);
    check(32'(sys_rst_n_o), 32'h0);
    // Supply not yet good: the sequencer must keep every clock gated off
    rst_n = 1'b1;
    step(6);
    check(32'(gate_o), 32'(GATE_NONE));
    supply_good = 1'b1;
    wait_active(4);
    $display("test power-up done");

    // Sleep keeps only peripherals clocked; wake returns in three cycles
    sleep_req = 1'b1;
    wait_mode(MODE_SLEEP, 3);
    sleep_req = 1'b0;
    check(32'(gate_o), 32'(GATE_SLEEP));
    step($urandom_range(1, 20));
    wake_event = 1'b1;
    step(1);
    wake_event = 1'b0;
    wait_active(4);
    $display("test sleep done");

    // Deep sleep stops the fast clock; wake must finish inside 3500 cycles
    deep_req = 1'b1;
    wait_mode(MODE_DEEP, 3);
    deep_req = 1'b0;
    check(32'(hf_osc_en_o), 32'h0);
    check(32'(gate_o), 32'(GATE_NONE));
    step(50);
    wake_event = 1'b1;
    step(1);
    wake_event = 1'b0;
    wait_active(WAKE_CYC);
    check(32'(hf_osc_en_o), 32'h1);
    $display("test deep sleep done");

    // Oscillator changes only while all distributed clocks are stopped
    for (int k = 0; k < 3; k++) begin
      freq_sel = ~freq_sel;
      n = 0;
      while (osc_sel_o !== freq_sel && n < 10) begin
        step(1);
        n++;
      end
      check(32'(osc_sel_o), 32'(freq_sel));
      check(32'(gate_o), 32'(GATE_NONE));
      wait_active(6);
    end
    $display("test oscillator select done");

    // Divider periods: zero as a corner, the rest drawn at random
    for (int d = 0; d < NUM_DIV; d++) begin
      div_val[d] = (d == 0) ? 16'h0000 : 16'($urandom_range(1, 9));
    end
    step(20);
    for (int d = 0; d < NUM_DIV; d++) begin
      n = 0;
      while (periph_tick_o[d] !== 1'b1 && n < 20) begin
        step(1);
        n++;
      end
      n = 0;
      do begin
        step(1);
        n++;
      end while (periph_tick_o[d] !== 1'b1 && n < 20);
      check(32'(n), 32'(div_val[d]) + 32'h1);
    end
    $display("test dividers done");

    // Watchdog counts ticks, a kick clears it, neglect resets the system
    cause_clr = 1'b1;
    step(1);
    cause_clr = 1'b0;
    step(1);
    check(32'(cause_o), 32'h0);
    wdt_enable = 1'b1;
    for (int k = 0; k < 2; k++) begin
      lfo_tick = 1'b1;
      step(1);
      lfo_tick = 1'b0;
      step(3);
    end
    check(32'(wdt_count_o), 32'h2);
    wdt_kick = 1'b1;
    step(1);
    wdt_kick = 1'b0;
    step(1);
    check(32'(wdt_count_o), 32'h0);
    n = 0;
    while (sys_rst_n_o === 1'b1 && n < 60) begin
      lfo_tick = (n % 4 == 0);
      step(1);
      n++;
    end
    lfo_tick = 1'b0;
    wdt_enable = 1'b0;
    check(32'(sys_rst_n_o), 32'h0);
    // Expiry on the tick that finds the count at the timeout, reset two edges on
    check(32'(n), 32'(wdt_timeout) * 32'h4 + 32'h2);
    // Oscillator returns to default one edge after the hold starts
    step(1);
    check(32'(osc_sel_o), 32'(OSC_SEL_24));
    check(32'(cause_o), 32'h10);
    check(32'(wdt_count_o), 32'h0);
    wait_active(30);
    check(32'(cause_o), 32'h10);
    step(10);
    wait_active(10);
    $display("test watchdog done");

    // Software, pin and brown-out sources, each replacing the record
    soft_rst_req = 1'b1;
    step(1);
    soft_rst_req = 1'b0;
    check(32'(sys_rst_n_o), 32'h0);
    check(32'(cause_o), 32'h08);
    wait_active(30);
    external_reset_pin_n = 1'b0;
    #1;
    check(32'(sys_rst_n_o), 32'h0);
    step(2);
    external_reset_pin_n = 1'b1;
    step(1);
    check(32'(cause_o), 32'h04);
    wait_active(30);
    brownout = 1'b1;
    #1;
    check(32'(sys_rst_n_o), 32'h0);
    step(2);
    brownout = 1'b0;
    step(1);
    check(32'(cause_o), 32'h02);
    wait_active(30);
    // Second power-on reset in mid-run
    rst_n = 1'b0;
    step(1);
    check(32'(cause_o), 32'(CAUSE_RST));
    check(32'(sys_rst_n_o), 32'h0);
    rst_n = 1'b1;
    wait_active(30);
    $display("test reset sources done");
    wrap_up();
  end
endmodule
